/* hdl/adc_conversion_control.v */
// Purpose: Status, control and result registers of an 8-bit four-channel converter.
// Assumes: One 100 MHz clock; register strobes are single-cycle and never overlap.
// Notes:   Read data stand in the cycle after the read strobe only.
//
// The register addresses and strobed register access are this design's own decisions.
`include "adc_ctrl_map.vh"

// Functional notes
// [RULE1] Interrupts disabled: completion flag sets at each conversion end.
// [RULE2] Completion flag holds until the result register is read.
// [RULE3] Reset clears the completion flag.
// [RULE4] Interrupts enabled: flag never sets and reads zero.
// [RULE5] Software writes zero into the completion flag position.
// [RULE6] Interrupt enabled: request raised at each conversion end; otherwise none.
// [RULE7] Result read or control write removes a pending request.
// [RULE8] Reset clears the interrupt enable.
// [RULE9] Continuous mode converts back to back, loading the result each time.
// [RULE10] Single mode converts once and stops.
// [RULE11] Reset clears continuous mode.
// [RULE12] Software should discard data of a conversion cut by a control write.
// [RULE13] Input taken from one of four channels shared with port pins.
// [RULE14] A control write aborts the running conversion and starts a new one; the code does so only for channel codes zero to three.
module adc_conversion_control #(
    parameter CYCLES = `CONV_CYCLES
) (
    input  wire        REF_CLK,
    input  wire        NRST,
    input  wire        CE,
    input  wire [1:0]  ADDR,
    input  wire [7:0]  WDATA,
    input  wire        WR,
    input  wire        RD,
    output reg  [7:0]  RDATA,
    output reg         IRQ,
    output wire        BUSY,
    output wire [3:0]  CHAN_ENABLE,
    input  wire [31:0] ANALOG_INPUT_VOLTAGE
);
    reg        conversion_complete_flag;
    reg        conv_interrupt_enable;
    reg        continuous_convert;
    reg  [4:0] channel_field;
    reg  [7:0] converter_clock_select;
    reg  [7:0] result;
    reg        restart;
    reg  [7:0] next_rdata;
    wire       busy;
    wire       done;
    wire [7:0] code;
    wire       ctrl_write = WR && ADDR == `ADDR_STATUS_CONTROL;
    wire       result_read = RD && ADDR == `ADDR_RESULT;
    wire       channel_valid = channel_field[4:2] == 3'h0;

    // Channel codes above three start no conversion, as the idle code; a running one goes on.
    wire start = (ctrl_write && WDATA[4:2] == 3'h0) || restart; // [RULE14]

    assign BUSY = busy;
    // Pin ownership follows the selected channel; other pins stay with the port. [RULE13]
    assign CHAN_ENABLE = (busy || channel_valid) && channel_field != `CHAN_IDLE ?
                         (4'h1 << channel_field[1:0]) : 4'h0;

    adc_sampler #(
        .CYCLES(CYCLES)
    ) u_sampler (
        .clk     (REF_CLK),
        .nrst    (NRST),
        .ce      (CE),
        .start   (start),
        .chan    (ctrl_write ? WDATA[1:0] : channel_field[1:0]), // [RULE13]
        .samples (ANALOG_INPUT_VOLTAGE),
        .busy    (busy),
        .done    (done),
        .code    (code)
    );

    always @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            conversion_complete_flag <= 1'b0; // [RULE3]
            conv_interrupt_enable    <= 1'b0; // [RULE8]
            continuous_convert       <= 1'b0; // [RULE11]
            channel_field            <= `CHAN_IDLE;
            converter_clock_select   <= `RESET_CLOCK_SELECT;
            result                   <= 8'h00;
            restart                  <= 1'b0;
            IRQ                      <= 1'b0;
            RDATA                    <= 8'h00;
        end else if (CE) begin
            RDATA   <= next_rdata;
            // Back-to-back only in continuous mode; single mode stops after one. [RULE9] [RULE10]
            restart <= done && continuous_convert && !ctrl_write;
            if (ctrl_write) begin
                // The written completion bit is ignored. [RULE5]
                conv_interrupt_enable <= WDATA[`FIELD_INT_ENABLE];
                continuous_convert    <= WDATA[`FIELD_CONTINUOUS];
                channel_field         <= WDATA[4:0];
            end
            if (WR && ADDR == `ADDR_CLOCK_SELECT)
                converter_clock_select <= WDATA;
            // A conversion finishing in the write cycle was cut short by that write. [RULE12]
            if (done && !ctrl_write)
                result <= code; // [RULE9]
            // Set wins over the clearing read of the same cycle.
            if (done && !ctrl_write && !conv_interrupt_enable)
                conversion_complete_flag <= 1'b1; // [RULE1]
            else if (result_read || conv_interrupt_enable)
                conversion_complete_flag <= 1'b0; // [RULE2] [RULE4]
            if (done && !ctrl_write && conv_interrupt_enable)
                IRQ <= 1'b1; // [RULE6]
            else if (result_read || ctrl_write || !conv_interrupt_enable)
                IRQ <= 1'b0; // [RULE7]
        end
    end

    always @* begin
        next_rdata = 8'h00;
        if (RD) begin
            case (ADDR)
                `ADDR_STATUS_CONTROL: next_rdata = {conversion_complete_flag
                                                    && !conv_interrupt_enable, // [RULE4]
                                                    conv_interrupt_enable,
                                                    continuous_convert, channel_field};
                `ADDR_RESULT:         next_rdata = result;
                `ADDR_CLOCK_SELECT:   next_rdata = converter_clock_select;
                default:              next_rdata = 8'h00;
            endcase
        end
    end
endmodule

/* hdl/adc_ctrl_map.vh */
// Purpose: Offsets, field positions, reset values and timing counts of the converter control.
// Assumes: Byte-wide registers on a plain strobe port.
// Notes:   Definitions only.
`ifndef ADC_CTRL_MAP_VH
`define ADC_CTRL_MAP_VH

`define ADDR_STATUS_CONTROL  2'h0
`define ADDR_RESULT          2'h1
`define ADDR_CLOCK_SELECT    2'h2

`define FIELD_COMPLETE       7
`define FIELD_INT_ENABLE     6
`define FIELD_CONTINUOUS     5
`define FIELD_CHAN_LSB       0
`define CHAN_IDLE            5'h1F

`define RESET_STATUS_CONTROL 8'h1F
`define RESET_CLOCK_SELECT   8'h00

`define CONV_TIME_NS         1000
`define CONV_CYCLES          ((`CONV_TIME_NS + 9) / 10)

`endif

/* hdl/adc_sampler.v */
// Purpose: Times one conversion and captures the selected channel.
// Assumes: Channel samples are digital codes synchronous to the clock.
// Notes:   A start pulse restarts a running conversion.
`include "adc_ctrl_map.vh"

module adc_sampler #(
    parameter CYCLES = `CONV_CYCLES
) (
    input  wire        clk,
    input  wire        nrst,
    input  wire        ce,
    input  wire        start,
    input  wire [1:0]  chan,
    input  wire [31:0] samples,
    output reg         busy,
    output reg         done,
    output reg  [7:0]  code
);
    reg [15:0] count;
    reg [1:0]  held_chan;

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            busy      <= 1'b0;
            done      <= 1'b0;
            code      <= 8'h00;
            count     <= 16'h0000;
            held_chan <= 2'h0;
        end else if (ce) begin
            done <= 1'b0;
            if (start) begin
                busy      <= 1'b1;
                count     <= 16'h0000;
                held_chan <= chan;
            end else if (busy) begin
                if (count == CYCLES[15:0] - 16'h0001) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                    code <= samples[held_chan * 8 +: 8];
                end else begin
                    count <= count + 16'h0001;
                end
            end
        end
    end
endmodule

/* tb/adc_conversion_control_bench.sv */
// Purpose: Directed checks of the converter control.
// Assumes: Conversion shortened to 4 cycles.
// Notes:   Expected results come from the model codes.
module adc_conversion_control_bench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [31:0] CODES = 32'hE1965A3C;
    logic clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, irq, busy;
    logic [1:0] addr = 2'h0;
    logic [7:0] wdata = 8'h00, rdata;
    logic [3:0] chan_en;
    logic [31:0] volts;
    int fail_count = 0, comparisons = 0, cycles = 0;
    always #5 clk = ~clk;
    adc_input_model #(.CODES(CODES)) model_u (.VOLTS(volts));
    adc_conversion_control #(.CYCLES(4)) dut_u (.REF_CLK(clk), .NRST(nrst), .CE(1'b1),
        .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .IRQ(irq),
        .BUSY(busy), .CHAN_ENABLE(chan_en), .ANALOG_INPUT_VOLTAGE(volts));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wreg(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk) {wr, addr, wdata} <= {1'b1, a, d};
        @(posedge clk) wr <= 1'b0;
    endtask
    task automatic rreg(input logic [1:0] a, input logic [7:0] exp);
        @(posedge clk) {rd, addr} <= {1'b1, a};
        @(posedge clk) rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask
    // Waits for the conversion to start and then to finish, with a bound on both.
    task automatic settle();
        repeat (20) @(negedge clk) if (busy === 1'b1) break;
        repeat (20) @(negedge clk) if (busy !== 1'b1) break;
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    always @(posedge clk) if (++cycles > 3000) begin
        fail_count++;
        wrap_up();
    end
    initial begin
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        rreg(2'h0, 8'h1F);
        chk({7'h0, irq}, 8'h00);
        wreg(2'h2, 8'h5A);
        rreg(2'h2, 8'h5A);
        rreg(2'h3, 8'h00);
        $display("reset test done");
        for (int n = 0; n < 4; n++) begin
            wreg(2'h0, 8'(n));
            settle();
            chk({4'h0, chan_en}, 8'h01 << n);
            repeat (6) @(negedge clk);
            chk({7'h0, busy}, 8'h00);
            repeat (2) rreg(2'h0, 8'h80 | 8'(n));
            rreg(2'h1, CODES[8*n +: 8]);
            rreg(2'h0, 8'(n));
        end
        $display("single test done");
        wreg(2'h0, 8'h42);
        settle();
        @(negedge clk);
        chk({7'h0, irq}, 8'h01);
        rreg(2'h0, 8'h42);
        rreg(2'h1, CODES[23:16]);
        chk({7'h0, irq}, 8'h00);
        wreg(2'h0, 8'h42);
        settle();
        wreg(2'h0, 8'h00);
        #1 chk({7'h0, irq}, 8'h00);
        wreg(2'h0, 8'h03);
        settle();
        rreg(2'h1, CODES[31:24]);
        $display("interrupt test done");
        wreg(2'h0, 8'h21);
        repeat (2) begin
            settle();
            rreg(2'h0, 8'hA1);
            rreg(2'h1, CODES[15:8]);
        end
        repeat (2) @(negedge clk);
        chk({7'h0, busy}, 8'h01);
        $display("continuous test done");
        wrap_up();
    end
endmodule

/* tb/adc_ctrl_checker.sv */
// Purpose: Port checks of the converter control.
// Assumes: One clock domain.
// Notes:   Shadow flops track the mode bits.
module adc_ctrl_checker #(parameter CYCLES = 4) (
    input logic REF_CLK, NRST, CE, WR, RD, IRQ, BUSY,
    input logic [1:0] ADDR,
    input logic [7:0] WDATA, RDATA,
    input logic [3:0] CHAN_ENABLE,
    input logic [31:0] ANALOG_INPUT_VOLTAGE
);
    logic cont, ie;
    wire  ctl_wr = WR && CE && ADDR == 2'h0;
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) {cont, ie} <= 2'h0;
        else if (ctl_wr) {cont, ie} <= {WDATA[5], WDATA[6]};
    end
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!NRST);
    sequence conv_end; $fell(BUSY); endsequence
    sequence restart; ##[1:3] BUSY; endsequence
    // The request is registered from the done pulse, so it rises one edge after BUSY fell.
    a_irq_at_end: assert property ($rose(IRQ) |-> $past(BUSY, 2) && !$past(BUSY))
        else $error("irq rose without conversion end");
    a_no_irq_off: assert property (!ie |-> !IRQ)
        else $error("irq while disabled");
    a_write_drops: assert property (ctl_wr |=> !IRQ)
        else $error("irq kept after control write");
    a_read_drops: assert property (RD && CE && ADDR == 2'h1 && !BUSY && !conv_end |=> !IRQ)
        else $error("irq kept after result read");
    a_flag_hidden: assert property (RD && CE && ADDR == 2'h0 && ie |=> !RDATA[7])
        else $error("flag read as one with irq enabled");
    a_start_busy: assert property (ctl_wr && WDATA[4:2] == 3'h0 |=> BUSY)
        else $error("write did not start conversion");
    a_back_back: assert property ($fell(BUSY) && cont |-> restart)
        else $error("continuous mode did not restart");
    a_single_stop: assert property ($fell(BUSY) && !cont && !WR |=> !BUSY)
        else $error("single mode restarted");
    a_chan_pick: assert property (ctl_wr && WDATA[4:2] == 3'h0 |=>
        CHAN_ENABLE == (4'h1 << $past(WDATA[1:0]))) else $error("wrong channel enable");
endmodule
bind adc_conversion_control adc_ctrl_checker #(.CYCLES(CYCLES)) chk_u (.REF_CLK(REF_CLK),
    .NRST(NRST), .CE(CE), .WR(WR), .RD(RD), .IRQ(IRQ), .BUSY(BUSY), .ADDR(ADDR),
    .WDATA(WDATA), .RDATA(RDATA), .CHAN_ENABLE(CHAN_ENABLE),
    .ANALOG_INPUT_VOLTAGE(ANALOG_INPUT_VOLTAGE));

/* tb/adc_input_model.sv */
// Purpose: Channel codes at the converter input.
// Assumes: Codes stay steady.
// Notes:   Distinct codes expose a wrong channel pick.
module adc_input_model #(parameter logic [31:0] CODES = 32'hE1965A3C) (
    output logic [31:0] VOLTS
);
    timeunit 1ns;
    timeprecision 1ns;
    assign VOLTS = CODES;
endmodule
